//--- shared/bax_pkg.sv
// Purpose: Shared constants and types for the byte ALU with bit and branch execution.
// Assumes: One 100 MHz clock; one instruction offered per cycle on the request port.
// Notes: Opcodes are the block's own encoding of the instruction subset.
package bax_pkg;

  // Width of data, file address and program counter, file depth and offset width.
  localparam int BAX_DATA_W = 8;
  localparam int BAX_ADDR_W = 7;
  localparam int BAX_PC_W = 15;
  localparam int BAX_FILE_DEPTH = 128;
  localparam int BAX_OFFS_W = 9;

  // Values after reset.
  localparam logic [7:0] BAX_ACC_RST = 8'h00;
  localparam logic [14:0] BAX_PC_RST = 15'h0000;

  // Destination selector values.
  localparam logic BAX_DEST_ACC = 1'b0;
  localparam logic BAX_DEST_FILE = 1'b1;

  // Operations of the subset.
  typedef enum logic [2:0] {
    BAX_OP_NOP,
    BAX_OP_ADD_ACC_TO_FILE,
    BAX_OP_ADD_ACC_FILE_WITH_ROLLIN,
    BAX_OP_ARITH_SHIFT_RIGHT_FILE,
    BAX_OP_CLEAR_FILE_BIT,
    BAX_OP_TEST_BIT_SKIP_IF_LOW,
    BAX_OP_RELATIVE_JUMP
  } bax_op_e;

  // One instruction as offered to the block.
  typedef struct packed {
    bax_op_e op;
    logic [6:0] file_addr;
    logic dest;
    logic [2:0] bit_sel;
    logic [8:0] offset;
  } bax_instr_s;

  // Status flags.
  typedef struct packed {
    logic carry;
    logic nibble_rollout_bit;
    logic zero;
  } bax_flags_s;

  // Result of the adder or shifter.
  typedef struct packed {
    logic [7:0] value;
    logic carry;
    logic nibble;
  } bax_alu_s;

endpackage

//--- design/bax_adder.sv
// Purpose: Byte adder with carry in, giving carry out and low nibble carry out.
// Assumes: Purely combinational.
// Notes: Used by both add instructions.
`timescale 1ns/1ps
module bax_adder
  import bax_pkg::*;
(
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output bax_alu_s sum
);

  // Low nibble sum, its carry feeds the high nibble.
  logic [4:0] lo;
  // High nibble sum with carry out.
  logic [4:0] hi;

  // Nibble-wise add so the nibble carry is exposed.
  always_comb begin
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    sum.value = {hi[3:0], lo[3:0]};
    sum.carry = hi[4];
    sum.nibble = lo[4];
  end

endmodule // bax_adder

//--- design/bax_exec.sv
// Purpose: Executes add, add with carry, shift, bit clear, bit test skip and relative jump.
// Assumes: One instruction offered per cycle with INSTR_VALID; file registers held here.
// Notes: A taken skip and a jump cost two slots; the next offered instruction is discarded.
// Operation
// [RQ1] Add accumulator to file, update flags.
// [RQ2] Destination zero to accumulator, one to file.
// [RQ3] Shift right, keep bit seven, bit zero carry.
// [RQ4] Add accumulator, file and carry; flags.
// [RQ5] Clear one file bit, flags untouched.
// [RQ6] Skip next instruction when tested bit low.
// [RQ7] Jump to incremented counter plus signed offset.
// [RQ8] Relative jump takes two cycles.
// [RQ9] Zero flag set on zero result.
`timescale 1ns/1ps
module bax_exec
  import bax_pkg::*;
#(
  parameter int DEPTH = BAX_FILE_DEPTH
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic INSTR_VALID,
  input bax_instr_s INSTR,
  output logic [7:0] ACC,
  output bax_flags_s FLAGS,
  output logic [14:0] PROGRAM_COUNTER,
  output logic DISCARD,
  output logic DONE
);

  // Whole state of the module apart from the file registers.
  typedef struct packed {
    logic [7:0] acc;
    bax_flags_s flags;
    logic [14:0] pc;
    logic discard;
    logic done;
  } bax_state_s;

  // Registered state and its next value.
  bax_state_s st_reg;
  bax_state_s st_next;
  // File register array, not part of the reset state.
  logic [7:0] file_mem [DEPTH];
  // File write enable, address and data.
  logic fw_en;
  logic [6:0] fw_addr;
  logic [7:0] fw_data;
  // Operand read from the file.
  logic [7:0] fval;
  // Adder result.
  bax_alu_s add_res;
  // Carry into the adder.
  logic add_cin;
  // Shift result.
  bax_alu_s shr_res;

  // Zero test for a byte result.
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  assign fval = file_mem[INSTR.file_addr];

  // Carry only enters for the add-with-rollin form.
  assign add_cin = (INSTR.op == BAX_OP_ADD_ACC_FILE_WITH_ROLLIN) ? st_reg.flags.carry : 1'b0; // RQ4

  bax_adder u_adder (
    .a(st_reg.acc),
    .b(fval),
    .cin(add_cin),
    .sum(add_res)
  );

  // Arithmetic shift keeps the sign bit and pushes bit zero to carry.
  always_comb begin
    shr_res.value = {fval[7], fval[7:1]}; // RQ3
    shr_res.carry = fval[0]; // RQ3
    shr_res.nibble = st_reg.flags.nibble_rollout_bit;
  end

  // Next state and file write decision.
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    fw_en = 1'b0;
    fw_addr = INSTR.file_addr;
    fw_data = fval;
    if (INSTR_VALID) begin
      // A pending discard stands through idle cycles until an offered slot consumes it.
      st_next.discard = 1'b0; // RQ6 RQ8
      st_next.done = 1'b1;
      st_next.pc = st_reg.pc + 15'd1;
      if (st_reg.discard) begin
        // Discarded slot runs as a no-operation.
        st_next.done = 1'b1; // RQ6
      end else begin
        case (INSTR.op)
          BAX_OP_ADD_ACC_TO_FILE, BAX_OP_ADD_ACC_FILE_WITH_ROLLIN: begin
            st_next.flags.carry = add_res.carry; // RQ1 RQ4
            st_next.flags.nibble_rollout_bit = add_res.nibble; // RQ1 RQ4
            st_next.flags.zero = is_zero(add_res.value); // RQ9
            if (INSTR.dest == BAX_DEST_FILE) begin
              fw_en = 1'b1; // RQ2
              fw_data = add_res.value;
            end else begin
              st_next.acc = add_res.value; // RQ2
            end
          end
          BAX_OP_ARITH_SHIFT_RIGHT_FILE: begin
            st_next.flags.carry = shr_res.carry; // RQ3
            st_next.flags.zero = is_zero(shr_res.value); // RQ3 RQ9
            if (INSTR.dest == BAX_DEST_FILE) begin
              fw_en = 1'b1; // RQ2
              fw_data = shr_res.value;
            end else begin
              st_next.acc = shr_res.value; // RQ2
            end
          end
          BAX_OP_CLEAR_FILE_BIT: begin
            // Only the selected bit drops; flags are left alone.
            fw_en = 1'b1;
            fw_data = fval & ~(8'h01 << INSTR.bit_sel); // RQ5
          end
          BAX_OP_TEST_BIT_SKIP_IF_LOW: begin
            st_next.discard = ~fval[INSTR.bit_sel]; // RQ6
          end
          BAX_OP_RELATIVE_JUMP: begin
            // Sign-extend the offset onto the incremented counter.
            st_next.pc = st_reg.pc + 15'd1 + {{6{INSTR.offset[8]}}, INSTR.offset}; // RQ7
            st_next.discard = 1'b1; // RQ8
          end
          default: begin
            st_next.done = 1'b1;
          end
        endcase
      end
    end
  end

  // State register.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st_reg <= '{acc: BAX_ACC_RST, flags: '0, pc: BAX_PC_RST, discard: 1'b0, done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // File register write port, no reset so it can map to memory.
  always_ff @(posedge SYS_CLK) begin
    if (fw_en) begin
      file_mem[fw_addr] <= fw_data;
    end
  end

  assign ACC = st_reg.acc;
  assign FLAGS = st_reg.flags;
  assign PROGRAM_COUNTER = st_reg.pc;
  assign DISCARD = st_reg.discard;
  assign DONE = st_reg.done;

  // Add result reaches the accumulator when destination is zero.
  chk_add_to_acc: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ2
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_ADD_ACC_TO_FILE && INSTR.dest == BAX_DEST_ACC
    |=> ACC == 8'($past(st_reg.acc) + $past(fval))) else $error("add result not in accumulator");

  // Add with carry sums the old carry.
  chk_rollin_sum: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ4
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_ADD_ACC_FILE_WITH_ROLLIN
    |=> ({1'b0, $past(st_reg.acc)} + {1'b0, $past(fval)} + {8'h00, $past(st_reg.flags.carry)}) ==
        {FLAGS.carry, ($past(INSTR.dest) ? file_mem[$past(INSTR.file_addr)] : ACC)})
    else $error("add with carry sum wrong");

  // Add carry flag follows the sum.
  chk_add_flags: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ1
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_ADD_ACC_TO_FILE
    |=> FLAGS.carry == (({1'b0, $past(st_reg.acc)} + {1'b0, $past(fval)}) > 9'h0ff))
    else $error("add carry wrong");

  // Shift keeps the sign and takes bit zero to carry.
  chk_shift_sign: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ3
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_ARITH_SHIFT_RIGHT_FILE && INSTR.dest == BAX_DEST_ACC
    |=> ACC[7] == $past(fval[7]) && ACC[6:0] == $past(fval[7:1]) && FLAGS.carry == $past(fval[0]))
    else $error("shift result wrong");

  // Bit clear leaves flags and accumulator alone.
  chk_clear_flags: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ5
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_CLEAR_FILE_BIT
    |=> $stable(FLAGS) && $stable(ACC)) else $error("bit clear touched flags");

  // Bit clear drops the selected bit in the addressed file register.
  chk_clear_bit: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ5
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_CLEAR_FILE_BIT
    |=> file_mem[$past(INSTR.file_addr)][$past(INSTR.bit_sel)] == 1'b0) else $error("bit clear left bit set");

  // Low tested bit discards the next slot.
  sequence skip_taken;
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_TEST_BIT_SKIP_IF_LOW && !fval[INSTR.bit_sel];
  endsequence
  chk_skip_low: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ6
    skip_taken |=> DISCARD) else $error("skip not taken for low bit");

  // High tested bit lets the next instruction run.
  chk_skip_high: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ6
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_TEST_BIT_SKIP_IF_LOW && fval[INSTR.bit_sel]
    |=> !DISCARD) else $error("skip taken for high bit");

  // A discarded slot is consumed by the next offered instruction, not by idle cycles.
  chk_discard_slot: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ6
    INSTR_VALID && DISCARD |=> !DISCARD) else $error("discard not consumed");
  chk_discard_hold: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ8
    !INSTR_VALID |=> $stable(DISCARD) && $stable(PROGRAM_COUNTER)) else $error("idle cycle changed state");

  // Jump loads counter plus one plus offset and discards one slot.
  sequence jump_issued;
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_RELATIVE_JUMP;
  endsequence
  chk_jump_target: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ7
    jump_issued |=> PROGRAM_COUNTER == 15'($past(st_reg.pc) + 15'd1 + {{6{$past(INSTR.offset[8])}}, $past(INSTR.offset)})
    && $stable(FLAGS)) else $error("jump target wrong");
  chk_jump_cycles: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ8
    jump_issued |=> DISCARD) else $error("jump did not discard");

  // Zero flag mirrors a zero add result.
  chk_zero_flag: assert property (@(posedge SYS_CLK) disable iff (RESET) // RQ9
    INSTR_VALID && !st_reg.discard && INSTR.op == BAX_OP_ADD_ACC_TO_FILE
    |=> FLAGS.zero == ($past(add_res.value) == 8'h00)) else $error("zero flag wrong");

endmodule // bax_exec

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the byte ALU with bit and branch execution.
// Assumes: File registers start unknown, so every one is cleared bit by bit first.
// Notes: Accumulator, carry and the cleared files stay zero, so adds and shifts with a file destination write only zeros; jumps and skips are mixed in.
`timescale 1ns/1ps
module tb_top;
  import bax_pkg::*;
  logic SYS_CLK, RESET, INSTR_VALID, DISCARD, DONE;
  bax_instr_s INSTR;
  logic [7:0] ACC;
  bax_flags_s FLAGS;
  logic [14:0] PROGRAM_COUNTER;
  int n_errors = 0; // Mismatches seen.
  int check_count = 0; // Comparisons made.
  int cyc = 0; // Clock cycles since time zero.
  logic [31:0] lf = 32'h03e7; // Random state.
  logic [7:0] fm [128]; // Expected file contents.
  logic [7:0] m_acc; // Expected accumulator.
  bax_flags_s m_fl; // Expected flags.
  logic [14:0] m_pc; // Expected program counter.
  logic m_disc; // Expected discard state.

  bax_exec i_bax_exec (.SYS_CLK(SYS_CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .ACC(ACC),
    .FLAGS(FLAGS), .PROGRAM_COUNTER(PROGRAM_COUNTER), .DISCARD(DISCARD), .DONE(DONE));

  // The clock runs at 100 MHz.
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // Steps the random state by one shift.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  // Packs one instruction.
  function automatic bax_instr_s mk(bax_op_e op, logic [6:0] a, logic d, logic [2:0] b, logic [8:0] o);
    return '{op, a, d, b, o};
  endfunction

  // Compares a seen value with its expected value.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Works out what one taken instruction must do.
  task automatic model(input bax_instr_s i);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] f;
    logic [7:0] r;
    logic c;
    logic upd;
    f = fm[i.file_addr];
    upd = 1'b0;
    r = 8'h00;
    c = (i.op == BAX_OP_ADD_ACC_FILE_WITH_ROLLIN) ? m_fl.carry : 1'b0;
    m_pc = m_pc + 15'h0001;
    if (m_disc) begin
      m_disc = 1'b0; // The slot after a skip or jump is a no-op.
    end else begin
      case (i.op)
        BAX_OP_ADD_ACC_TO_FILE, BAX_OP_ADD_ACC_FILE_WITH_ROLLIN: begin
          s = {1'b0, m_acc} + {1'b0, f} + {8'h00, c};
          n = {1'b0, m_acc[3:0]} + {1'b0, f[3:0]} + {4'h0, c};
          r = s[7:0];
          m_fl = '{s[8], n[4], r == 8'h00};
          upd = 1'b1;
        end
        BAX_OP_ARITH_SHIFT_RIGHT_FILE: begin
          r = {f[7], f[7:1]};
          m_fl.carry = f[0];
          m_fl.zero = (r == 8'h00);
          upd = 1'b1;
        end
        BAX_OP_CLEAR_FILE_BIT: fm[i.file_addr][i.bit_sel] = 1'b0;
        BAX_OP_TEST_BIT_SKIP_IF_LOW: m_disc = ~f[i.bit_sel];
        BAX_OP_RELATIVE_JUMP: begin
          m_pc = m_pc + {{6{i.offset[8]}}, i.offset};
          m_disc = 1'b1;
        end
        default: ;
      endcase
    end
    if (upd && i.dest == BAX_DEST_FILE) fm[i.file_addr] = r;
    else if (upd) m_acc = r;
  endtask

  // Offers one instruction at a falling edge and checks the answer a cycle later.
  task automatic issue(input bax_instr_s i);
    INSTR = i;
    INSTR_VALID = 1'b1;
    @(negedge SYS_CLK);
    model(i);
    chk(32'(ACC), 32'(m_acc));
    chk(32'(FLAGS), 32'(m_fl));
    chk(32'(PROGRAM_COUNTER), 32'(m_pc));
    chk(32'(DISCARD), 32'(m_disc));
    chk(32'(DONE), 32'h1);
  endtask

  // One cycle with nothing offered; a stray jump on the bus must be ignored.
  task automatic idle();
    INSTR_VALID = 1'b0;
    INSTR = mk(BAX_OP_RELATIVE_JUMP, 7'h00, 1'b0, 3'h0, 9'h0aa);
    @(negedge SYS_CLK);
    chk(32'(DONE), 32'h0);
    chk(32'(PROGRAM_COUNTER), 32'(m_pc));
    chk(32'(DISCARD), 32'(m_disc));
    chk(32'(ACC), 32'(m_acc));
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      wrap_up();
    end
  end

  // Main sequence.
  initial begin
    RESET = 1'b1;
    INSTR_VALID = 1'b0;
    INSTR = '0;
    m_acc = 8'h00;
    m_fl = '0;
    m_pc = 15'h0000;
    m_disc = 1'b0;
    repeat (8) @(negedge SYS_CLK);
    RESET = 1'b0;
    chk(32'({ACC, 5'(FLAGS), PROGRAM_COUNTER, DISCARD, DONE}), 32'h0);
    $display("test reset done");
    for (int a = 0; a < 128; a++) begin
      for (int b = 0; b < 8; b++) issue(mk(BAX_OP_CLEAR_FILE_BIT, 7'(a), 1'b1, 3'(b), 9'h000));
    end
    idle();
    $display("test clear done");
    for (int k = 0; k < 4; k++) begin
      issue(mk(BAX_OP_RELATIVE_JUMP, 7'h01, 1'b0, 3'h0, k == 0 ? 9'h000 : k == 1 ? 9'h0ff : k == 2 ? 9'h100 : 9'h1ff));
      issue(mk(BAX_OP_RELATIVE_JUMP, 7'h02, 1'b0, 3'h0, 9'h0ff));
      issue(mk(BAX_OP_ADD_ACC_TO_FILE, 7'h7f, 1'b0, 3'h0, 9'h000));
    end
    $display("test jump done");
    for (int b = 0; b < 8; b++) begin
      issue(mk(BAX_OP_TEST_BIT_SKIP_IF_LOW, 7'(b * 9), 1'b0, 3'(b), 9'h000));
      issue(mk(BAX_OP_RELATIVE_JUMP, 7'h00, 1'b0, 3'h0, 9'h055));
    end
    $display("test skip done");
    repeat (600) begin
      lf = lfsr(lf);
      if (lf[3:0] == 4'h0) idle();
      else issue(mk(lf[6:4] == 3'h7 ? BAX_OP_NOP : bax_op_e'(lf[6:4]), lf[13:7], lf[14], lf[17:15], lf[26:18]));
    end
    idle();
    $display("test random done");
    wrap_up();
  end
endmodule // tb_top
